// ---- hw/core_control_cfg.svh ----
`ifndef CORE_CONTROL_CFG_SVH
`define CORE_CONTROL_CFG_SVH

// ------------------------------------------------------------
// register map, byte addresses
// ------------------------------------------------------------
`define CC_ADDR 8'h00
`define PL_ADDR 8'h04

// ------------------------------------------------------------
// core_control layout and reset
// ------------------------------------------------------------
`define CC_RESET 16'h0020
`define CC_RW_MASK 16'hB0F3
`define CC_EDT 11
`define CC_DL_MSB 10
`define CC_DL_LSB 8
`define CC_SATA 7
`define CC_SATB 6
`define CC_SATDW 5
`define CC_SAT_MODE 4
`define CC_PRIO3 3
`define CC_SFA 2

// ------------------------------------------------------------
// status word priority field
// ------------------------------------------------------------
`define STATUS_PRIO_MSB 7
`define STATUS_PRIO_LSB 5

// ------------------------------------------------------------
// saturation limits
// ------------------------------------------------------------
`define NORM_MAX 40'h00_7FFF_FFFF
`define NORM_MIN 40'hFF_8000_0000
`define SUPER_MAX 40'h7F_FFFF_FFFF
`define SUPER_MIN 40'h80_0000_0000
`define WORD_MAX 16'h7FFF
`define WORD_MIN 16'h8000
`define DEPTH_MAX 3'h7
`define DEPTH_MIN 3'h0

`endif

// ---- hw/core_control_pkg.sv ----
package core_control_pkg;
	typedef logic signed [39:0] acc_t;
	typedef logic signed [40:0] raw_t;
	typedef logic [15:0] word_t;
	typedef logic [2:0] depth_t;
	typedef logic [3:0] level_t;
endpackage : core_control_pkg

// ---- hw/sat_if.sv ----
`timescale 1ns/1ps
interface sat_if;
	logic sat_a;
	logic sat_b;
	logic sat_dw;
	logic super_sat;
	logic acc_sel;
	core_control_pkg::raw_t acc_raw;
	core_control_pkg::acc_t acc_res;
	core_control_pkg::acc_t dsw_src;
	core_control_pkg::word_t dsw_word;

	modport ctl
	(
		output sat_a, sat_b, sat_dw, super_sat, acc_sel, acc_raw, dsw_src,
		input acc_res, dsw_word
	);
	modport unit
	(
		input sat_a, sat_b, sat_dw, super_sat, acc_sel, acc_raw, dsw_src,
		output acc_res, dsw_word
	);
endinterface : sat_if

// ---- hw/saturation_unit.sv ----
`timescale 1ns/1ps
`include "core_control_cfg.svh"
module saturation_unit
(
	// control and data from the core control block
	sat_if.unit s
);
	// ------------------------------------------------------------
	// clamp to 9.31 or 1.31, or wrap when disabled
	// ------------------------------------------------------------
	function automatic core_control_pkg::acc_t clamp
	(
		input core_control_pkg::raw_t v,
		input logic super_sat,
		input logic en
	);
		core_control_pkg::raw_t hi;
		core_control_pkg::raw_t lo;
		hi = super_sat ? core_control_pkg::raw_t'($signed(`SUPER_MAX))
			: core_control_pkg::raw_t'($signed(`NORM_MAX));
		lo = super_sat ? core_control_pkg::raw_t'($signed(`SUPER_MIN))
			: core_control_pkg::raw_t'($signed(`NORM_MIN));
		if (!en)
			clamp = v[39:0];
		else if (v > hi)
			clamp = hi[39:0];
		else if (v < lo)
			clamp = lo[39:0];
		else
			clamp = v[39:0];
	endfunction : clamp

	core_control_pkg::acc_t dsw_clamped;

	always_comb
	begin
		s.acc_res = clamp(s.acc_raw, s.super_sat, s.acc_sel ? s.sat_b : s.sat_a);
		// data-space words always use the 1.31 limit
		dsw_clamped = clamp({s.dsw_src[39], s.dsw_src}, 1'b0, s.sat_dw);
		s.dsw_word = dsw_clamped[31:16];
	end
endmodule : saturation_unit

// ---- hw/core_control_saturation.sv ----
// Contract
// - priority level is control bit three above status word bits 7 to 5.
// - writing one to early termination ends the loop after current iteration.
// - accumulator A results saturate only while its saturation enable is set.
// - accumulator B results saturate only while its saturation enable is set.
// - engine writes to data space clamp only while that enable is set.
// - mode bit picks super saturation with guard bits or plain 31-bit clamp.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "core_control_cfg.svh"
module core_control_saturation
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// cpu status and priority
	input wire logic [15:0] cpu_status_word,
	input wire logic priority_level_bit_three_set,
	input wire logic frame_active,
	output core_control_pkg::level_t cpu_priority_level,
	// hardware loop tracking
	input wire logic loop_start,
	input wire logic loop_iter_end,
	input wire logic loop_finish,
	output logic loop_terminate,
	output core_control_pkg::depth_t loop_nesting_count,
	// accumulator writes
	input wire logic acc_wr_valid,
	input wire logic acc_wr_sel,
	input wire core_control_pkg::raw_t acc_wr_value,
	output core_control_pkg::acc_t accumulator_a,
	output core_control_pkg::acc_t accumulator_b,
	// data-space writes from the engine
	input wire logic dsw_req,
	input wire logic dsw_acc_sel,
	output logic dsw_valid,
	output core_control_pkg::word_t dsw_data
);
	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic req, wr_fire;
	logic [15:0] wmask;
	core_control_pkg::word_t cc_view;

	assign req = wb_cyc_i & wb_stb_i;
	// writes land on the edge that sees ack, as the master expects
	assign wr_fire = req & wb_we_i & ack_q & (wb_adr_i == `CC_ADDR);
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_comb
	begin
		ack_d = req & ~ack_q;
		rdat_d = rdat_q;
		if (req & ~ack_q)
		begin
			// unmapped addresses still ack, reading zero
			unique case (wb_adr_i)
				`CC_ADDR: rdat_d = {16'h0000, cc_view};
				`PL_ADDR: rdat_d = {28'h0000000, cpu_priority_level};
				default: rdat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ------------------------------------------------------------
	// control register and priority level
	// ------------------------------------------------------------
	logic [15:0] rw_q, rw_d;
	logic prio3_q, prio3_d;
	logic edt_set;
	core_control_pkg::level_t level_q, level_d;

	always_comb
	begin
		rw_d = rw_q;
		if (wr_fire)
			rw_d = (rw_q & ~(wmask & `CC_RW_MASK)) | (wb_dat_i[15:0] & wmask & `CC_RW_MASK);
		// software may only clear; a same-cycle set wins
		prio3_d = priority_level_bit_three_set
			| (prio3_q & ~(wr_fire & wb_sel_i[0] & ~wb_dat_i[`CC_PRIO3]));
		// registered: the level trails its inputs by one cycle
		level_d = {prio3_q, cpu_status_word[`STATUS_PRIO_MSB:`STATUS_PRIO_LSB]};
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rw_q <= `CC_RESET;
			prio3_q <= 1'b0;
			level_q <= 4'h0;
		end
		else
		begin
			rw_q <= rw_d;
			prio3_q <= prio3_d;
			level_q <= level_d;
		end
	end

	assign cpu_priority_level = level_q;
	// writing zero to termination does nothing
	assign edt_set = wr_fire & wb_sel_i[1] & wb_dat_i[`CC_EDT];

	// ------------------------------------------------------------
	// hardware loop nesting and early termination
	// ------------------------------------------------------------
	core_control_pkg::depth_t depth_q, depth_d;
	logic pending_q, pending_d;
	logic term_q, term_d;
	logic pop;

	always_comb
	begin
		// request only acts while a loop is live
		term_d = pending_q & loop_iter_end & (depth_q != `DEPTH_MIN);
		pop = term_d | loop_finish;
		depth_d = depth_q;
		if (loop_start & ~pop & (depth_q != `DEPTH_MAX))
			depth_d = depth_q + 3'h1;
		else if (pop & ~loop_start & (depth_q != `DEPTH_MIN))
			depth_d = depth_q - 3'h1;
		// new request in the consuming cycle survives
		pending_d = edt_set | (pending_q & ~loop_iter_end & (depth_q != `DEPTH_MIN));
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			depth_q <= 3'h0;
			pending_q <= 1'b0;
			term_q <= 1'b0;
		end
		else
		begin
			depth_q <= depth_d;
			pending_q <= pending_d;
			term_q <= term_d;
		end
	end

	assign loop_terminate = term_q;
	assign loop_nesting_count = depth_q;

	// termination reads back as zero
	assign cc_view = rw_q | {5'h00, depth_q, 4'h0, prio3_q, frame_active, 2'h0};

	// ------------------------------------------------------------
	// accumulator and data-space saturation
	// ------------------------------------------------------------
	sat_if s ();
	core_control_pkg::acc_t acc_a_q, acc_a_d, acc_b_q, acc_b_d;
	logic dsw_valid_q, dsw_valid_d;
	core_control_pkg::word_t dsw_data_q, dsw_data_d;

	assign s.sat_a = rw_q[`CC_SATA];
	assign s.sat_b = rw_q[`CC_SATB];
	assign s.sat_dw = rw_q[`CC_SATDW];
	assign s.super_sat = rw_q[`CC_SAT_MODE];
	assign s.acc_sel = acc_wr_sel;
	assign s.acc_raw = acc_wr_value;
	assign s.dsw_src = dsw_acc_sel ? acc_b_q : acc_a_q;

	saturation_unit u_sat
	(
		.s(s.unit)
	);

	always_comb
	begin
		acc_a_d = acc_a_q;
		acc_b_d = acc_b_q;
		if (acc_wr_valid & ~acc_wr_sel)
			acc_a_d = s.acc_res;
		if (acc_wr_valid & acc_wr_sel)
			acc_b_d = s.acc_res;
		dsw_valid_d = dsw_req;
		dsw_data_d = dsw_req ? s.dsw_word : dsw_data_q;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			acc_a_q <= 40'h00_0000_0000;
			acc_b_q <= 40'h00_0000_0000;
			dsw_valid_q <= 1'b0;
			dsw_data_q <= 16'h0000;
		end
		else
		begin
			acc_a_q <= acc_a_d;
			acc_b_q <= acc_b_d;
			dsw_valid_q <= dsw_valid_d;
			dsw_data_q <= dsw_data_d;
		end
	end

	assign accumulator_a = acc_a_q;
	assign accumulator_b = acc_b_q;
	assign dsw_valid = dsw_valid_q;
	assign dsw_data = dsw_data_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_level_join;
		##1 cpu_priority_level == {$past(prio3_q), $past(cpu_status_word[7:5])};
	endproperty
	a_level_join: assert property (p_level_join) else $error("priority level mismatch");

	property p_depth_up;
		loop_start && !loop_finish && !pending_q && depth_q != 3'h7
			|=> loop_nesting_count == $past(depth_q) + 3'h1;
	endproperty
	a_depth_up: assert property (p_depth_up) else $error("nesting did not count up");

	property p_depth_down;
		loop_finish && !loop_start && depth_q != 3'h0
			|=> loop_nesting_count == $past(depth_q) - 3'h1;
	endproperty
	a_depth_down: assert property (p_depth_down) else $error("nesting did not drop");

	property p_early_term;
		##1 loop_terminate == $past(pending_q && loop_iter_end && depth_q != 3'h0);
	endproperty
	a_early_term: assert property (p_early_term) else $error("early termination wrong");

	property p_acc_a_wrap;
		acc_wr_valid && !acc_wr_sel && !rw_q[`CC_SATA]
			|=> accumulator_a == $past(acc_wr_value[39:0]);
	endproperty
	a_acc_a_wrap: assert property (p_acc_a_wrap) else $error("acc a clamped while off");

	property p_acc_b_wrap;
		acc_wr_valid && acc_wr_sel && !rw_q[`CC_SATB]
			|=> accumulator_b == $past(acc_wr_value[39:0]);
	endproperty
	a_acc_b_wrap: assert property (p_acc_b_wrap) else $error("acc b clamped while off");

	property p_acc_b_sat;
		acc_wr_valid && acc_wr_sel && rw_q[`CC_SATB] && rw_q[`CC_SAT_MODE]
			&& acc_wr_value > $signed({1'b0, `SUPER_MAX}) |=> accumulator_b == `SUPER_MAX;
	endproperty
	a_acc_b_sat: assert property (p_acc_b_sat) else $error("acc b not saturated");

	property p_dsw_clamp;
		dsw_req && rw_q[`CC_SATDW] && s.dsw_src > $signed(`NORM_MAX)
			|=> dsw_valid && dsw_data == `WORD_MAX;
	endproperty
	a_dsw_clamp: assert property (p_dsw_clamp) else $error("data write not clamped");

	property p_dsw_wrap;
		dsw_req && !rw_q[`CC_SATDW] |=> dsw_valid && dsw_data == $past(s.dsw_src[31:16]);
	endproperty
	a_dsw_wrap: assert property (p_dsw_wrap) else $error("data write clamped while off");

	property p_dsw_pulse;
		!dsw_req |=> !dsw_valid;
	endproperty
	a_dsw_pulse: assert property (p_dsw_pulse) else $error("data write valid unasked");

	property p_normal_sat;
		acc_wr_valid && !acc_wr_sel && rw_q[`CC_SATA] && !rw_q[`CC_SAT_MODE]
			&& acc_wr_value < $signed({1'b1, `NORM_MIN}) |=> accumulator_a == `NORM_MIN;
	endproperty
	a_normal_sat: assert property (p_normal_sat) else $error("normal clamp wrong");

	c_term: cover property (edt_set ##[1:20] loop_terminate);
	c_dsw_sat: cover property (dsw_valid && dsw_data == `WORD_MIN);
	c_deep: cover property (loop_nesting_count == 3'h7);
	c_super: cover property (acc_wr_valid && rw_q[`CC_SAT_MODE]);
endmodule : core_control_saturation

// ---- testbench/core_control_saturation_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module core_control_saturation_bench;
	logic clk = 0;
	logic reset_n = 0;
	logic cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [15:0] status = 16'h0000;
	logic set3 = 0, frame = 0, lstart = 0, liter = 0, lfin = 0;
	logic lterm;
	core_control_pkg::depth_t depth;
	core_control_pkg::level_t level;
	logic av = 0, asel = 0, dreq = 0, dsel = 0, dvalid;
	core_control_pkg::raw_t araw = 41'h0;
	core_control_pkg::acc_t acc_a, acc_b;
	core_control_pkg::word_t dword;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [15:0] q;

	always #2 clk = ~clk;

	core_control_saturation i_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .cpu_status_word(status),
		.priority_level_bit_three_set(set3), .frame_active(frame),
		.cpu_priority_level(level), .loop_start(lstart), .loop_iter_end(liter),
		.loop_finish(lfin), .loop_terminate(lterm), .loop_nesting_count(depth),
		.acc_wr_valid(av), .acc_wr_sel(asel), .acc_wr_value(araw),
		.accumulator_a(acc_a), .accumulator_b(acc_b), .dsw_req(dreq),
		.dsw_acc_sel(dsel), .dsw_valid(dvalid), .dsw_data(dword));

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	// hang guard: whole run is under two hundred cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// bus and stimulus helpers
	// ----------------------------------------
	task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic sat_case(input logic [15:0] cc, input logic s,
		input core_control_pkg::raw_t r, input core_control_pkg::acc_t e);
		wb(8'h00, 1'b1, cc);
		@(posedge clk);
		av <= 1'b1;
		asel <= s;
		araw <= r;
		@(posedge clk);
		av <= 1'b0;
		@(posedge clk);
		`CHK("acc", e, (s ? acc_b : acc_a))
	endtask : sat_case

	task automatic dsw_case(input logic sel, input logic [15:0] cc, input logic [15:0] e);
		wb(8'h00, 1'b1, cc);
		@(posedge clk);
		dreq <= 1'b1;
		dsel <= sel;
		@(posedge clk);
		dreq <= 1'b0;
		@(posedge clk);
		`CHK("dsw_valid", 1'b1, dvalid)
		`CHK("dsw_data", e, dword)
	endtask : dsw_case

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		wb(8'h00, 1'b0, 16'h0000);
		`CHK("cc reset", 16'h0020, q)
		frame <= 1'b1;
		wb(8'h00, 1'b0, 16'h0000);
		`CHK("frame bit", 16'h0024, q)
		frame <= 1'b0;
		wb(8'h08, 1'b0, 16'h0000);
		`CHK("unmapped", 16'h0000, q)
	endtask : t_reset

	task automatic t_level;
		status <= 16'h00A0;
		set3 <= 1'b1;
		@(posedge clk);
		set3 <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("level", 4'hD, level)
		wb(8'h04, 1'b0, 16'h0000);
		`CHK("level reg", 16'h000D, q)
		wb(8'h00, 1'b1, 16'h0020);
		repeat (3) @(posedge clk);
		`CHK("level clr", 4'h5, level)
	endtask : t_level

	task automatic t_loops;
		lstart <= 1'b1;
		repeat (9) @(posedge clk);
		lstart <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		`CHK("depth max", 3'h7, depth)
		lfin <= 1'b1;
		@(posedge clk);
		lfin <= 1'b0;
		@(posedge clk);
		wb(8'h00, 1'b0, 16'h0000);
		`CHK("depth field", 3'h6, q[10:8])
		wb(8'h00, 1'b1, 16'h0820);
		wb(8'h00, 1'b0, 16'h0000);
		`CHK("term reads 0", 1'b0, q[11])
		liter <= 1'b1;
		@(posedge clk);
		liter <= 1'b0;
		@(posedge clk);
		`CHK("terminate", 1'b1, lterm)
		@(posedge clk);
		`CHK("depth after", 3'h5, depth)
		wb(8'h00, 1'b1, 16'h0820);
		wb(8'h00, 1'b1, 16'h0020);
		liter <= 1'b1;
		@(posedge clk);
		liter <= 1'b0;
		@(posedge clk);
		`CHK("zero kept request", 1'b1, lterm)
		liter <= 1'b1;
		@(posedge clk);
		liter <= 1'b0;
		@(posedge clk);
		`CHK("no terminate", 1'b0, lterm)
		`CHK("depth end", 3'h4, depth)
	endtask : t_loops

	initial
	begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_level();
		t_loops();
		sat_case(16'h0000, 1'b0, 41'h001_0000_0000, 40'h01_0000_0000);
		sat_case(16'h0080, 1'b0, 41'h001_0000_0000, 40'h00_7FFF_FFFF);
		sat_case(16'h0090, 1'b0, 41'h001_0000_0000, 40'h01_0000_0000);
		sat_case(16'h0090, 1'b0, 41'h080_0000_0000, 40'h7F_FFFF_FFFF);
		sat_case(16'h0000, 1'b1, 41'h1FF_0000_0000, 40'hFF_0000_0000);
		sat_case(16'h0040, 1'b1, 41'h1FF_0000_0000, 40'hFF_8000_0000);
		sat_case(16'h0050, 1'b1, 41'h100_0000_0000, 40'h80_0000_0000);
		sat_case(16'h0000, 1'b0, 41'h001_0000_0000, 40'h01_0000_0000);
		dsw_case(1'b0, 16'h0020, 16'h7FFF);
		dsw_case(1'b0, 16'h0000, 16'h0000);
		dsw_case(1'b1, 16'h0020, 16'h8000);
		wrap_up();
	end
endmodule : core_control_saturation_bench
